/* File: rtl/rmp_regs.svh */
// register offsets, field positions, reset values and timing figures of the
// radio module parameter decoder; included by the core only
`ifndef RMP_REGS_SVH
`define RMP_REGS_SVH

// ======
// register byte offsets
`define RMP_OFS_CFG     8'h00
`define RMP_OFS_ADDR    8'h04
`define RMP_OFS_NET     8'h08
`define RMP_OFS_KEY     8'h0C
`define RMP_OFS_DELAY   8'h10
`define RMP_OFS_STATUS  8'h14

// ======
// field positions in the net and status words
`define RMP_NET_CHAN_LSB    8
`define RMP_ST_UPG_BIT      2
`define RMP_ST_AUX_BIT      3
`define RMP_ST_RPT_BIT      4
`define RMP_ST_BUSY_BIT     5

// ======
// reset values of the user parameters
`define RMP_RST_CFG     17'h00003
`define RMP_RST_ADDR    16'h0000
`define RMP_RST_CHAN    7'h17
`define RMP_RST_NETID   8'h00
`define RMP_RST_KEY     16'h0000
`define RMP_RST_DELAY   16'h0000

// ======
// timing
`define RMP_CLK_HZ        250000000
`define RMP_UPG_TIME_S    60
`define RMP_RELOAD_TIME_US 100
`define RMP_PERIOD_STEP_MS 500

`endif

/* File: rtl/rmp_pkg.sv */
// types shared by the parameter decoder core and its bench
// assumes rmp_regs.svh holds every number
package rmp_pkg;

  // ======
  // user parameter word, laid out as the configuration register
  typedef struct packed {
    logic       drssi;
    logic       erssi;
    logic       lbt;
    logic       router;
    logic       trans;
    logic [2:0] period;
    logic       wor_role;
    logic [2:0] air;
    logic [1:0] parity;
    logic [2:0] baud;
  } rmp_cfg_t;

  typedef enum logic [1:0] {RMP_NORMAL, RMP_WOR, RMP_CONFIG, RMP_SLEEP} rmp_mode_t;
  typedef enum logic [1:0] {RMP_8N1, RMP_8O1, RMP_8E1} rmp_parity_t;
  typedef enum logic [1:0] {RMP_BAND_400, RMP_BAND_900, RMP_BAND_230} rmp_band_t;

  // radio packet seen by the forwarding path
  typedef struct packed {
    logic       valid;
    logic [7:0] netid;
  } rmp_pkt_t;

  typedef enum {P_A, P_T, P_PLUS, P_NAME, P_VAL, P_SKIP, P_REPLY} rmp_pstate_t;

endpackage : rmp_pkg

/* File: rtl/rmp_core.sv */
// text command decoder, parameter store and repeater steering of the radio module
// assumes the serial byte stream, radio packets and bus share clk_i; the mode pins
// come from outside and are synchronised here
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "rmp_regs.svh"

// Notes on behaviour
// - good command answers name=OK, else =ERR; the code answers =OK without the name when junk follows a good value
// - speed code 0..7 gives 1200..115200 baud
// - parity 0,3 none; 1 odd; 2 even
// - 400/900 air rate table up to 62.5K
// - 230 band air rate table up to 15.6K
// - wake role 0 receive, 1 transmit
// - wake period code times 500 ms plus 500
// - transfer mode 0 transparent, 1 fixed point
// - address 0..65535, larger refused
// - channel limit 83, 80 or 64 by band
// - network identifier 0..255
// - key 0..65535
// - wake sleep delay 0..65535
// - working mode 0,1,2 selects normal, wake, config
// - upgrade command taken only in config mode
// - upgrade ends only after 60 s powered
// - upgrade forces 115200 baud and log output
// - forwarding starts only in normal mode
// - address bytes pair two networks, forward across
// - own network identifier ignored when repeating
// - repeater blocks serial data and low power
// - reload after reset/sleep, status low meanwhile
module rmp_core #(
  parameter rmp_pkg::rmp_band_t BAND          = rmp_pkg::RMP_BAND_400,
  parameter logic [35:0]        UPG_CYCLES    = 36'(64'(`RMP_UPG_TIME_S) * `RMP_CLK_HZ),
  parameter int                 RELOAD_CYCLES = `RMP_RELOAD_TIME_US * (`RMP_CLK_HZ / 1000000)
) (
  input  wire logic              clk_i,                 // 250 MHz clock
  input  wire logic              rst_i,                 // synchronous reset
  input  wire logic              por_i,                 // power-on reset, also clears upgrade
  // wishbone classic slave
  input  wire logic              wb_cyc_i,              // bus cycle
  input  wire logic              wb_stb_i,              // strobe
  input  wire logic              wb_we_i,               // write enable
  input  wire logic [7:0]        wb_adr_i,              // byte address
  input  wire logic [3:0]        wb_sel_i,              // byte lanes
  input  wire logic [31:0]       wb_dat_i,              // write data
  output logic [31:0]            wb_dat_o,              // read data
  output logic                   wb_ack_o,              // acknowledge
  // mode pins
  input  wire logic              mode_select_pin_zero_i, // asynchronous mode pin
  input  wire logic              mode_select_pin_one_i,  // asynchronous mode pin
  // command bytes from the serial receiver
  input  wire logic [7:0]        rx_data_i,             // received byte
  input  wire logic              rx_valid_i,            // byte present
  output logic                   rx_ready_o,            // byte taken
  // reply bytes to the serial transmitter
  output logic [7:0]             tx_data_o,             // reply byte
  output logic                   tx_valid_o,            // reply byte present
  input  wire logic              tx_ready_i,            // transmitter takes byte
  // radio packets
  input  wire rmp_pkg::rmp_pkt_t pkt_i,                 // received packet header
  output rmp_pkg::rmp_pkt_t      fwd_o,                 // packet to resend
  output logic                   deliver_o,             // packet goes to serial port
  // decoded settings
  output logic [16:0]            baud_rate_o,           // serial speed in baud
  output rmp_pkg::rmp_parity_t   parity_o,              // frame format
  output logic [9:0]             air_rate_o,            // air rate in 100 bit/s
  output logic [12:0]            wake_period_ms_o,      // wake period in ms
  output logic                   wake_tx_role_o,        // wake transmitter role
  output logic                   fixed_point_o,         // fixed point sending
  output rmp_pkg::rmp_mode_t     mode_o,                // working mode
  output logic                   upgrade_o,             // upgrade mode
  output logic                   log_en_o,              // log output on
  output logic                   aux_o,                 // status indicator
  output logic                   user_data_en_o,        // serial user data allowed
  output logic                   low_power_en_o         // low power allowed
);

  // ======
  // state
  rmp_pkg::rmp_cfg_t   cfg;
  logic [15:0]         addr, key, delay;
  logic [6:0]          chan;
  logic [7:0]          netid;
  rmp_pkg::rmp_mode_t  mode;
  logic [1:0]          pin_q1, pin_q2, pin_last;
  logic                upgrade;
  logic [35:0]         upg_cnt;
  logic [31:0]         reload_cnt;
  rmp_pkg::rmp_pstate_t pst;
  logic [63:0]         nm;
  logic [3:0]          nlen, ri;
  logic [16:0]         v0, v1;
  logic [1:0]          nv;
  logic                ok;
  logic                tx_valid;
  logic [7:0]          tx_data;
  logic                rpt_active, reloading, execute;
  logic                any_rst;

  assign any_rst   = rst_i | por_i;
  assign reloading = (reload_cnt != 32'h0);

  // ======
  // helpers
  function automatic logic [16:0] acc(input logic [16:0] v, input logic [7:0] c);
    logic [20:0] t;
    t = 21'(v) * 21'h00000A + 21'(c - 8'h30);
    acc = (t > 21'h010000) ? 17'h10000 : t[16:0]; // saturate so overflow stays visible
  endfunction : acc

  function automatic logic [63:0] nm_of(input string s);
    nm_of = 64'h0;
    for (int i = 0; i < s.len(); i++) nm_of = {nm_of[55:0], 8'(s[i])};
  endfunction : nm_of

  function automatic logic [7:0] tail(input logic good, input logic [3:0] k);
    logic [47:0] t;
    t = good ? 48'h3D4F4B0D0A00 : 48'h3D4552520D0A;
    tail = t[47 - 8 * int'(k) -: 8];
  endfunction : tail

  // ======
  // mode pin synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    pin_q1 <= {mode_select_pin_one_i, mode_select_pin_zero_i};
    pin_q2 <= pin_q1;
  end

  // ======
  // working mode: pins decide on change, command may override
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      mode     <= rmp_pkg::RMP_NORMAL;
      pin_last <= 2'h0;
    end else begin
      pin_last <= pin_q2;
      if (pin_q2 != pin_last || reloading)
        mode <= rmp_pkg::rmp_mode_t'(pin_q2);
      else if (execute && ok && nm == nm_of("MODE") && nlen == 4'h4)
        mode <= rmp_pkg::rmp_mode_t'(v0[1:0]);
    end
  end

  // ======
  // reload window after reset or on leaving deep sleep
  always_ff @(posedge clk_i) begin
    if (any_rst)
      reload_cnt <= 32'(RELOAD_CYCLES);
    else if (pin_last == 2'h3 && pin_q2 != 2'h3)
      reload_cnt <= 32'(RELOAD_CYCLES);
    else if (reloading)
      reload_cnt <= reload_cnt - 32'h1;
  end

  // ======
  // upgrade mode survives rst_i; only power-on or the timer running out clears it, so a restart
  // before the timer runs out lands in upgrade mode again
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      upgrade <= 1'b0;
      upg_cnt <= 36'h0;
    end else if (upgrade) begin
      if (upg_cnt >= UPG_CYCLES - 36'h1) begin
        upgrade <= 1'b0;
        upg_cnt <= 36'h0;
      end else begin
        upg_cnt <= upg_cnt + 36'h1;
      end
    end else if (execute && ok && nm == nm_of("IAP") && nlen == 4'h3) begin
      upgrade <= 1'b1;
    end
  end

  // ======
  // command validation, decided on the line end
  always_comb begin
    logic cfgm;
    logic [16:0] chmax;
    cfgm  = (mode == rmp_pkg::RMP_CONFIG);
    chmax = (BAND == rmp_pkg::RMP_BAND_400) ? 17'd83 :
            (BAND == rmp_pkg::RMP_BAND_900) ? 17'd80 : 17'd64;
    ok    = 1'b0;
    unique case (nlen)
      4'h3: ok = (nm == nm_of("IAP") && nv == 2'h0 && cfgm) ||
                 (nm == nm_of("WOR") && cfgm && v0 <= 17'h1 && nv != 2'h0 &&
                  (nv == 2'h1 || v1 <= 17'h7)) ||
                 (nm == nm_of("LBT") && cfgm && nv == 2'h1 && v0 <= 17'h1) ||
                 (nm == nm_of("KEY") && cfgm && nv == 2'h1 && v0 <= 17'hFFFF);
      4'h4: ok = (nm == nm_of("UART") && cfgm && nv == 2'h2 && v0 <= 17'h7 && v1 <= 17'h3) ||
                 (nm == nm_of("RATE") && cfgm && nv == 2'h1 && v0 <= 17'h7) ||
                 (nm == nm_of("ADDR") && cfgm && nv == 2'h1 && v0 <= 17'hFFFF) ||
                 (nm == nm_of("MODE") && nv == 2'h1 && v0 <= 17'h2);
      4'h5: ok = cfgm && nv == 2'h1 &&
                 (((nm == nm_of("TRANS") || nm == nm_of("ERSSI") || nm == nm_of("DRSSI")) &&
                   v0 <= 17'h1) ||
                  (nm == nm_of("NETID") && v0 <= 17'hFF) ||
                  (nm == nm_of("DELAY") && v0 <= 17'hFFFF));
      4'h6: ok = nm == nm_of("ROUTER") && cfgm && nv == 2'h1 && v0 <= 17'h1;
      4'h7: ok = nm == nm_of("CHANNEL") && cfgm && nv == 2'h1 && v0 <= chmax;
      default: ok = 1'b0;
    endcase
  end

  // ======
  // line parser: AT+NAME=v[,v] ended by CR or LF
  assign execute    = rx_valid_i && rx_ready_o && (rx_data_i == 8'h0D || rx_data_i == 8'h0A) &&
                      (pst == rmp_pkg::P_NAME || pst == rmp_pkg::P_VAL || pst == rmp_pkg::P_SKIP);
  assign rx_ready_o = (pst != rmp_pkg::P_REPLY) && !reloading && !rpt_active;

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pst  <= rmp_pkg::P_A;
      nm   <= 64'h0;
      nlen <= 4'h0;
      v0   <= 17'h0;
      v1   <= 17'h0;
      nv   <= 2'h0;
    end else if (pst == rmp_pkg::P_REPLY) begin
      if (ri == 4'hF && !tx_valid)
        pst <= rmp_pkg::P_A;
    end else if (rx_valid_i && rx_ready_o) begin
      unique case (pst)
        rmp_pkg::P_A:    pst <= (rx_data_i == 8'h41) ? rmp_pkg::P_T : rmp_pkg::P_A;
        rmp_pkg::P_T:    pst <= (rx_data_i == 8'h54) ? rmp_pkg::P_PLUS : rmp_pkg::P_SKIP;
        rmp_pkg::P_PLUS: begin
          pst  <= (rx_data_i == 8'h2B) ? rmp_pkg::P_NAME : rmp_pkg::P_SKIP;
          nm   <= 64'h0;
          nlen <= 4'h0;
          v0   <= 17'h0;
          v1   <= 17'h0;
          nv   <= 2'h0;
        end
        rmp_pkg::P_NAME: begin
          if (execute) begin
            pst <= rmp_pkg::P_REPLY;
          end else if (rx_data_i == 8'h3D) begin
            pst <= rmp_pkg::P_VAL;
          end else if (rx_data_i >= 8'h41 && rx_data_i <= 8'h5A && nlen != 4'h8) begin
            nm   <= {nm[55:0], rx_data_i};
            nlen <= nlen + 4'h1;
          end else begin
            pst <= rmp_pkg::P_SKIP;
          end
        end
        rmp_pkg::P_VAL: begin
          if (execute) begin
            pst <= rmp_pkg::P_REPLY;
          end else if (rx_data_i >= 8'h30 && rx_data_i <= 8'h39) begin
            if (nv == 2'h2)
              v1 <= acc(v1, rx_data_i);
            else
              v0 <= acc(v0, rx_data_i);
            if (nv == 2'h0)
              nv <= 2'h1;
          end else if (rx_data_i == 8'h2C && nv == 2'h1) begin
            nv <= 2'h2;
          end else begin
            pst <= rmp_pkg::P_SKIP; // malformed value: answer follows ok of the part read before it
          end
        end
        rmp_pkg::P_SKIP: begin
          if (execute) begin
            nlen <= 4'h0; // cleared after ok is latched, so the answer still follows the name read and omits it
            pst  <= rmp_pkg::P_REPLY;
          end
        end
        rmp_pkg::P_REPLY: pst <= rmp_pkg::P_REPLY;
      endcase
    end
  end

  // ======
  // reply sender: name then =OK, or =ERR alone; ri 15 marks done
  logic good_q;
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      ri       <= 4'h0;
      good_q   <= 1'b0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (execute) begin
      ri     <= 4'h0;
      good_q <= ok;
    end else if (pst == rmp_pkg::P_REPLY && ri != 4'hF && (!tx_valid || tx_ready_i)) begin
      tx_valid <= 1'b1;
      if (good_q && ri < nlen)
        tx_data <= nm[8 * (int'(nlen) - 1 - int'(ri)) +: 8];
      else
        tx_data <= tail(good_q, good_q ? ri - nlen : ri);
      if ((good_q && ri == nlen + 4'h4) || (!good_q && ri == 4'h5))
        ri <= 4'hF;
      else
        ri <= ri + 4'h1;
    end else if (tx_ready_i) begin
      tx_valid <= 1'b0;
    end
  end
  assign tx_valid_o = tx_valid;
  assign tx_data_o  = tx_data;

  // ======
  // parameter store, written by accepted commands and by the bus
  logic bus_wr;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF;

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      cfg   <= `RMP_RST_CFG;
      addr  <= `RMP_RST_ADDR;
      chan  <= `RMP_RST_CHAN;
      netid <= `RMP_RST_NETID;
      key   <= `RMP_RST_KEY;
      delay <= `RMP_RST_DELAY;
    end else if (execute && ok) begin
      unique case (nm)
        nm_of("UART"):    {cfg.parity, cfg.baud} <= {v1[1:0], v0[2:0]};
        nm_of("RATE"):    cfg.air      <= v0[2:0];
        nm_of("WOR"): begin
          cfg.wor_role <= v0[0];
          if (nv == 2'h2)
            cfg.period <= v1[2:0];
        end
        nm_of("TRANS"):   cfg.trans    <= v0[0];
        nm_of("ROUTER"):  cfg.router   <= v0[0];
        nm_of("LBT"):     cfg.lbt      <= v0[0];
        nm_of("ERSSI"):   cfg.erssi    <= v0[0];
        nm_of("DRSSI"):   cfg.drssi    <= v0[0];
        nm_of("ADDR"):    addr         <= v0[15:0];
        nm_of("CHANNEL"): chan         <= v0[6:0];
        nm_of("NETID"):   netid        <= v0[7:0];
        nm_of("KEY"):     key          <= v0[15:0];
        nm_of("DELAY"):   delay        <= v0[15:0];
        default:          cfg          <= cfg;
      endcase
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        `RMP_OFS_CFG:   cfg   <= wb_dat_i[16:0];
        `RMP_OFS_ADDR:  addr  <= wb_dat_i[15:0];
        `RMP_OFS_NET:   {chan, netid} <= wb_dat_i[14:0];
        `RMP_OFS_KEY:   key   <= wb_dat_i[15:0];
        `RMP_OFS_DELAY: delay <= wb_dat_i[15:0];
        default:        cfg   <= cfg; // unmapped writes ignored
      endcase
    end
  end

  // ======
  // wishbone: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        `RMP_OFS_CFG:    wb_dat_o <= {15'h0, cfg};
        `RMP_OFS_ADDR:   wb_dat_o <= {16'h0, addr};
        `RMP_OFS_NET:    wb_dat_o <= {17'h0, chan, netid};
        `RMP_OFS_DELAY:  wb_dat_o <= {16'h0, delay};
        `RMP_OFS_STATUS: wb_dat_o <= {26'h0, pst == rmp_pkg::P_REPLY, rpt_active,
                                      aux_o, upgrade, mode};
        default:         wb_dat_o <= 32'h0; // key is never readable back
      endcase
    end
  end

  // ======
  // decoded settings, registered
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      baud_rate_o      <= 17'h0;
      parity_o         <= rmp_pkg::RMP_8N1;
      air_rate_o       <= 10'h0;
      wake_period_ms_o <= 13'h0;
    end else begin
      unique case (upgrade ? 3'h7 : cfg.baud)
        3'h0: baud_rate_o <= 17'd1200;
        3'h1: baud_rate_o <= 17'd2400;
        3'h2: baud_rate_o <= 17'd4800;
        3'h3: baud_rate_o <= 17'd9600;
        3'h4: baud_rate_o <= 17'd19200;
        3'h5: baud_rate_o <= 17'd38400;
        3'h6: baud_rate_o <= 17'd57600;
        3'h7: baud_rate_o <= 17'd115200;
      endcase
      parity_o <= (cfg.parity == 2'h1) ? rmp_pkg::RMP_8O1 :
                  (cfg.parity == 2'h2) ? rmp_pkg::RMP_8E1 : rmp_pkg::RMP_8N1;
      if (BAND == rmp_pkg::RMP_BAND_230) begin
        unique case (cfg.air)
          3'h4:       air_rate_o <= 10'd48;
          3'h5:       air_rate_o <= 10'd96;
          3'h6, 3'h7: air_rate_o <= 10'd156;
          default:    air_rate_o <= 10'd24;
        endcase
      end else begin
        unique case (cfg.air)
          3'h3:    air_rate_o <= 10'd48;
          3'h4:    air_rate_o <= 10'd96;
          3'h5:    air_rate_o <= 10'd192;
          3'h6:    air_rate_o <= 10'd384;
          3'h7:    air_rate_o <= 10'd625;
          default: air_rate_o <= 10'd24;
        endcase
      end
      wake_period_ms_o <= 13'((int'(cfg.period) + 1) * `RMP_PERIOD_STEP_MS);
    end
  end

  // ======
  // repeater steering: address bytes name the two networks
  assign rpt_active = cfg.router && mode == rmp_pkg::RMP_NORMAL && !reloading;

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      fwd_o     <= '0;
      deliver_o <= 1'b0;
    end else begin
      fwd_o.valid <= rpt_active && pkt_i.valid &&
                     (pkt_i.netid == addr[15:8] || pkt_i.netid == addr[7:0]);
      fwd_o.netid <= (pkt_i.netid == addr[15:8]) ? addr[7:0] : addr[15:8];
      // own network identifier only matters outside repeating
      deliver_o   <= !rpt_active && pkt_i.valid && pkt_i.netid == netid;
    end
  end

  // ======
  // plain status outputs
  assign wake_tx_role_o = cfg.wor_role;
  assign fixed_point_o  = cfg.trans;
  assign mode_o         = mode;
  assign upgrade_o      = upgrade;
  assign log_en_o       = upgrade;
  assign aux_o          = !reloading;
  assign user_data_en_o = !rpt_active;
  assign low_power_en_o = !rpt_active;

endmodule : rmp_core
`default_nettype wire

/* File: bench/rmp_chk.sv */
// concurrent checks on the ports of the parameter decoder core
// assumes one clock and the synchronous resets of the core
`timescale 1ns/100ps
`default_nettype none
module rmp_chk #(
  parameter logic [35:0] UPG_CYCLES = 36'h0000000C8
) (
  input wire logic               clk_i,          // clock
  input wire logic               rst_i,          // reset
  input wire logic               por_i,          // power-on reset
  input wire logic [7:0]         tx_data_o,      // reply byte
  input wire logic               tx_valid_o,     // reply offered
  input wire logic               tx_ready_i,     // reply taken
  input wire rmp_pkg::rmp_pkt_t  pkt_i,          // packet in
  input wire rmp_pkg::rmp_pkt_t  fwd_o,          // packet resent
  input wire logic               deliver_o,      // to serial
  input wire logic [16:0]        baud_rate_o,    // baud
  input wire rmp_pkg::rmp_mode_t mode_o,         // mode
  input wire logic               upgrade_o,      // upgrade
  input wire logic               log_en_o,       // log on
  input wire logic               aux_o,          // status pin
  input wire logic               rx_ready_o,     // byte taken
  input wire logic               user_data_en_o, // serial data
  input wire logic               low_power_en_o  // low power
);
  // upgrade time; runs on through rst_i since upgrade itself survives it
  logic [35:0] upg_cnt;
  always_ff @(posedge clk_i) begin
    if (por_i || !upgrade_o) upg_cnt <= '0;
    else upg_cnt <= upg_cnt + 36'h000000001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence s_stall; tx_valid_o && !tx_ready_i; endsequence
  sequence s_upg; upgrade_o ##1 upgrade_o; endsequence
  a_reply_hold: assert property (s_stall |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before taken");
  a_upg_speed: assert property (s_upg |-> baud_rate_o == 17'h1C200 && log_en_o)
    else $error("upgrade without fixed speed and log");
  a_upg_time: assert property ($fell(upgrade_o) |-> upg_cnt >= UPG_CYCLES - 36'h2)
    else $error("upgrade ended early");
  a_upg_entry: assert property ($rose(upgrade_o) |-> $past(mode_o) == rmp_pkg::RMP_CONFIG)
    else $error("upgrade entered outside config mode");
  a_fwd_cause: assert property (fwd_o.valid |-> $past(pkt_i.valid) && $past(mode_o) == rmp_pkg::RMP_NORMAL)
    else $error("forward without packet in normal mode");
  a_rpt_quiet: assert property (fwd_o.valid |-> !user_data_en_o && !low_power_en_o && !deliver_o)
    else $error("repeater passes serial data or sleeps");
  a_reload_low: assert property ($fell(rst_i) |-> (!aux_o && !rx_ready_o) [*4])
    else $error("status high during reload");
  a_aux_gate: assert property (!aux_o |-> !rx_ready_o)
    else $error("bytes taken while status low");
endmodule : rmp_chk
bind rmp_core rmp_chk #(.UPG_CYCLES(UPG_CYCLES)) u_chk (.clk_i, .rst_i, .por_i, .tx_data_o, .tx_valid_o,
  .tx_ready_i, .pkt_i, .fwd_o, .deliver_o, .baud_rate_o, .mode_o, .upgrade_o, .log_en_o, .aux_o,
  .rx_ready_o, .user_data_en_o, .low_power_en_o);
`default_nettype wire

/* File: bench/rmp_host.sv */
// host on the serial byte streams: sends queued bytes, collects replies
// assumes the bench fills out_q and reads in_q; slow stalls the replies
`timescale 1ns/100ps
`default_nettype none
module rmp_host (
  input  wire logic       clk_i,      // clock
  output logic [7:0]      rx_data_o,  // byte to core
  output logic            rx_valid_o, // byte offered
  input  wire logic       rx_ready_i, // byte taken
  input  wire logic [7:0] tx_data_i,  // reply byte
  input  wire logic       tx_valid_i, // reply offered
  output logic            tx_ready_o  // reply taken
);
  logic [7:0] out_q[$];
  logic [7:0] in_q[$];
  logic       slow = 1'b0;
  initial rx_data_o = 8'h00;
  initial rx_valid_o = 1'b0;
  initial tx_ready_o = 1'b1;
  // idle line toggles so a stale byte never looks valid
  always @(posedge clk_i) begin
    if (rx_valid_o && rx_ready_i) void'(out_q.pop_front());
    rx_valid_o <= out_q.size() != 0;
    rx_data_o <= out_q.size() != 0 ? out_q[0] : ~rx_data_o;
    if (tx_valid_i && tx_ready_o) in_q.push_back(tx_data_i);
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
endmodule : rmp_host
`default_nettype wire

/* File: bench/testbench.sv */
// bench of the parameter decoder: commands, bus access, upgrade, repeater
// assumes rmp_host on the byte streams and rmp_chk bound to the core
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              por_i = 1'b1;
  logic              cyc = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       dat = 32'h00000000;
  logic [31:0]       rd;
  logic [1:0]        pins = 2'h2;
  rmp_pkg::rmp_pkt_t pkt = '0;
  logic [7:0]        rxd, txd;
  logic              rxv, rxr, txv, txr;
  int                errors = 0, total_checks = 0, cycles = 0;
  logic [16:0] baud_t [8] = '{17'h004B0, 17'h00960, 17'h012C0, 17'h02580, 17'h04B00, 17'h09600, 17'h0E100, 17'h1C200};
  logic [9:0]  air_t [8] = '{10'h018, 10'h018, 10'h018, 10'h030, 10'h060, 10'h0C0, 10'h180, 10'h271};
  rmp_core #(.UPG_CYCLES(36'h0000000C8), .RELOAD_CYCLES(8)) u_dut (.clk_i, .rst_i, .por_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(), .wb_ack_o(),
    .mode_select_pin_zero_i(pins[0]), .mode_select_pin_one_i(pins[1]), .rx_data_i(rxd), .rx_valid_i(rxv),
    .rx_ready_o(rxr), .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr), .pkt_i(pkt), .fwd_o(),
    .deliver_o(), .baud_rate_o(), .parity_o(), .air_rate_o(), .wake_period_ms_o(), .wake_tx_role_o(),
    .fixed_point_o(), .mode_o(), .upgrade_o(), .log_en_o(), .aux_o(), .user_data_en_o(), .low_power_en_o());
  rmp_host u_host (.clk_i, .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_ready_o(txr));
  always #2 clk_i = ~clk_i;
  // ======
  // run guard and reporting
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // ======
  // transfer tasks
  task cmd(input string n, input string v, input bit ok);
    string s;
    string r;
    s = {"AT+", n, v == "" ? "" : {"=", v}, "\r"};
    r = ok ? {n, "=OK\r\n"} : "=ERR\r\n";
    u_host.in_q = {};
    foreach (s[i]) u_host.out_q.push_back(s[i]);
    for (int k = 0; k < 400 && u_host.in_q.size() < r.len(); k++) @(posedge clk_i);
    foreach (r[i]) check(u_host.in_q[i], r[i]);
  endtask : cmd
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (u_dut.wb_ack_o !== 1'b1);
    rd = u_dut.wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task pk(input logic [7:0] n, input logic v, input logic [7:0] e);
    pkt <= '{1'b1, n};
    @(posedge clk_i);
    pkt <= '0;
    @(posedge clk_i);
    check(u_dut.fwd_o.valid, v);
    if (v) check(u_dut.fwd_o.netid, e);
    check(u_dut.deliver_o, 1'b0);
  endtask : pk
  task reload;
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(u_dut.aux_o, 1'b0);
    for (int k = 0; k < 40 && u_dut.aux_o !== 1'b1; k++) @(posedge clk_i);
    check(u_dut.aux_o, 1'b1);
  endtask : reload
  task pins_to(input logic [1:0] p);
    pins <= p;
    repeat (6) @(posedge clk_i);
    check(u_dut.mode_o, p);
  endtask : pins_to
  // ======
  // scenarios
  task t_decode;
    for (int k = 0; k < 8; k++) begin
      cmd("UART", $sformatf("%0d,%0d", k, k % 4), 1'b1);
      check(u_dut.baud_rate_o, baud_t[k]);
      check(u_dut.parity_o, 32'(k % 4 == 3 ? 0 : k % 4));
      cmd("RATE", $sformatf("%0d", k), 1'b1);
      check(u_dut.air_rate_o, air_t[k]);
    end
  endtask : t_decode
  task t_refuse;
    u_host.slow = 1'b1;
    cmd("ADDR", "65536", 1'b0);
    cmd("ADDR", "65535", 1'b1);
    cmd("CHANNEL", "84", 1'b0);
    cmd("CHANNEL", "83", 1'b1);
    cmd("NETID", "256", 1'b0);
    u_host.slow = 1'b0;
  endtask : t_refuse
  task t_upgrade;
    cmd("IAP", "", 1'b1);
    check(u_dut.upgrade_o, 1'b1);
    check(u_dut.baud_rate_o, 17'h1C200);
    check(u_dut.log_en_o, 1'b1);
    rst_i <= 1'b1;
    @(posedge clk_i);
    reload();
    check(u_dut.upgrade_o, 1'b1);
    for (int k = 0; k < 300 && u_dut.upgrade_o !== 1'b0; k++) @(posedge clk_i);
    check(u_dut.upgrade_o, 1'b0);
  endtask : t_upgrade
  task t_repeat;
    wb(1'b1, 8'h04, 32'h00000833);
    wb(1'b0, 8'h04, 32'h00000000);
    check(rd, 32'h00000833);
    wb(1'b0, 8'h20, 32'h00000000);
    check(rd, 32'h00000000);
    cmd("ROUTER", "1", 1'b1);
    pk(8'h08, 1'b0, 8'h00);
    pins_to(2'h0);
    pk(8'h08, 1'b1, 8'h33);
    pk(8'h33, 1'b1, 8'h08);
    pk(8'h00, 1'b0, 8'h00);
    check(u_dut.user_data_en_o, 1'b0);
    check(u_dut.low_power_en_o, 1'b0);
  endtask : t_repeat
  initial begin
    repeat (2) @(posedge clk_i);
    reload();
    pins_to(2'h2);
    t_decode();
    t_refuse();
    t_upgrade();
    t_repeat();
    close_out();
  end
endmodule : testbench
`default_nettype wire
